// [logic/rmseq_pkg.sv]
// constants, types and helpers shared by the radio mode sequencer
`default_nettype none
package rmseq_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int TURNON_US = 1400;
  localparam int RELOCK_US = 490;
  localparam int TURNON_CYC = TURNON_US * CLK_MHZ;
  localparam int RELOCK_CYC = RELOCK_US * CLK_MHZ;
  localparam int SER_HALF_NS = 50;
  localparam int SER_HALF_CYC = (SER_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 20;
  localparam logic [4:0] SER_LAST_BIT = 5'h0F;
  localparam logic [5:0] SER_DIV_LAST = 6'(SER_HALF_CYC - 1);

  // ==========================================================
  // software register map of the sequencer
  localparam logic [7:0] SW_CMD = 8'h00;
  localparam logic [7:0] SW_CFGW = 8'h04;
  localparam logic [7:0] SW_STATUS = 8'h08;
  localparam logic [7:0] SW_TURNON = 8'h0C;
  localparam logic [7:0] SW_RELOCK = 8'h10;
  localparam logic [7:0] SW_OOK = 8'h14;
  localparam logic [7:0] SW_RATE = 8'h18;
  localparam logic [7:0] SW_BIAS = 8'h1C;
  localparam logic [7:0] SW_LAST_RD = 8'h20;
  localparam logic [31:0] OOK_RST = 32'h0000_0000;
  localparam logic [31:0] RATE_RST = 32'h0000_0000;
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam logic [15:0] MIN_OOK_RATE = 16'h0060;

  // commands written to SW_CMD
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_CFG_DONE = 3'h1;
  localparam logic [2:0] CMD_RX = 3'h2;
  localparam logic [2:0] CMD_TX = 3'h3;
  localparam logic [2:0] CMD_PD = 3'h4;

  // ==========================================================
  // device registers and fields reached over the serial port
  localparam logic [6:0] DEV_MAIN = 7'h00;
  localparam logic [6:0] DEV_MODEM = 7'h08;
  localparam logic [6:0] DEV_GAIN_TWO = 7'h10;
  localparam logic [6:0] DEV_BIAS = 7'h12;
  localparam logic [6:0] DEV_CAL = 7'h14;
  localparam logic [6:0] DEV_STATUS = 7'h40;
  localparam int MAIN_RESET_N = 0;
  localparam int MAIN_XOSC_PD = 1;
  localparam int MAIN_FS_PD = 2;
  localparam int MAIN_TX_PD = 3;
  localparam int MAIN_RX_PD = 4;
  localparam int MAIN_DIR_TX = 7;
  localparam logic [7:0] CAL_START_WORD = 8'h80;
  localparam int STAT_CAL_DONE = 7;
  localparam int STAT_LOCK = 4;
  localparam logic [7:0] GAIN_AVG_MASK = 8'h03;
  localparam logic [7:0] MODEM_MANCH = 8'h01;
  localparam logic [7:0] MODEM_AFC = 8'h80;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_PD = 2'h0,
    MODE_RX = 2'h1,
    MODE_TX = 2'h2
  } rmseq_mode_t;

  typedef enum logic [12:0] {
    ST_RST_ASSERT = 13'h0001,
    ST_RST_RELEASE = 13'h0002,
    ST_CONFIG = 13'h0004,
    ST_WAKE = 13'h0008,
    ST_CAL_START = 13'h0010,
    ST_CAL_POLL = 13'h0020,
    ST_LOCK_POLL = 13'h0040,
    ST_BIAS = 13'h0080,
    ST_OOK_GAIN = 13'h0100,
    ST_OOK_MODEM = 13'h0200,
    ST_SETUP = 13'h0400,
    ST_SETTLE = 13'h0800,
    ST_ACTIVE = 13'h1000
  } rmseq_state_t;

  // main control word: separate power-down bits per section
  function automatic logic [7:0] main_word(input logic rst_n, input logic fs_on,
                                            input logic rx_on, input logic tx_on,
                                            input logic dir_tx);
    logic [7:0] w;
    w = 8'h00;
    w[MAIN_RESET_N] = rst_n;
    w[MAIN_XOSC_PD] = 1'b0;
    w[MAIN_FS_PD] = ~fs_on;
    w[MAIN_RX_PD] = ~rx_on;
    w[MAIN_TX_PD] = ~tx_on;
    w[MAIN_DIR_TX] = dir_tx;
    return w;
  endfunction : main_word
endpackage : rmseq_pkg
`default_nettype wire

// [logic/rmseq_bus_if.sv]
// request and answer signals between sequencer and serial engine
`timescale 1ns/1ns
`default_nettype none
interface rmseq_bus_if;
  logic req;
  logic wr;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic busy;
  logic done;
  logic [7:0] rdata;
  modport master (output req, output wr, output addr, output wdata,
                  input busy, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata,
                  output busy, output done, output rdata);
endinterface : rmseq_bus_if
`default_nettype wire

// [logic/rmseq_serial.sv]
// four-wire serial configuration engine: 7 address bits, r/w, 8 data bits
`timescale 1ns/1ns
`default_nettype none
module rmseq_serial (
  input wire logic core_clk,
  input wire logic rst,
  rmseq_bus_if.engine bus,
  output logic ser_sel_n,
  output logic ser_clk,
  output logic ser_dout,
  input wire logic ser_din
);
  import rmseq_pkg::*;

  logic din_meta;
  logic din_sync;
  logic [5:0] div;
  logic [4:0] bitn;
  logic [15:0] shreg;
  logic [7:0] rshift;

  // ==========================================================
  // input synchroniser for the device data out pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      din_meta <= ser_din;
      din_sync <= din_meta;
    end
  end

  // ==========================================================
  // frame engine: data changes on clock low, device samples on rising edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus.busy <= 1'b0;
      bus.done <= 1'b0;
      bus.rdata <= 8'h00;
      ser_sel_n <= 1'b1;
      ser_clk <= 1'b0;
      ser_dout <= 1'b0;
      div <= 6'h00;
      bitn <= 5'h00;
      shreg <= 16'h0000;
      rshift <= 8'h00;
    end else begin
      bus.done <= 1'b0;
      if (!bus.busy) begin
        if (bus.req) begin
          bus.busy <= 1'b1;
          ser_sel_n <= 1'b0;
          ser_clk <= 1'b0;
          ser_dout <= bus.addr[6];
          shreg <= {bus.addr, bus.wr, bus.wdata};
          div <= 6'h00;
          bitn <= 5'h00;
        end
      end else if (div == SER_DIV_LAST) begin
        div <= 6'h00;
        if (!ser_clk) begin
          ser_clk <= 1'b1;
          rshift <= {rshift[6:0], din_sync}; // last eight samples are read data
        end else begin
          ser_clk <= 1'b0;
          if (bitn == SER_LAST_BIT) begin
            bus.busy <= 1'b0;
            bus.done <= 1'b1;
            bus.rdata <= rshift;
            ser_sel_n <= 1'b1; // idle select high, also through power-down R18
          end else begin
            bitn <= bitn + 5'h01;
            shreg <= {shreg[14:0], 1'b0};
            ser_dout <= shreg[14];
          end
        end
      end else begin
        div <= div + 6'h01;
      end
    end
  end
endmodule : rmseq_serial
`default_nettype wire

// [logic/rmseq_top.sv]
// host-side mode and power sequencer for a uhf transceiver
//
// Notes on behaviour
// R01: device powers sections down by separate bits
// R02: soft reset first after power-up
// R03: config writes any order, only non-defaults
// R04: reset, init, rx cal, tx cal, then use
// R05: leave power-down by wake then setup
// R06: rx/tx swap uses setup step only
// R07: turn-on settles 1400 us narrowest loop
// R08: rx/tx relock up to 490 us
// R09: bias set per direction before use
// R10: zero deviation mantissa selects on-off keying
// R11: on-off keying transmit uses full depth
// R12: on-off receive slices against carrier threshold
// R13: on-off keying needs gain averaging three
// R14: filter four or two times symbol rate
// R15: on-off keying always manchester coded
// R16: no frequency correction with on-off keying
// R17: on-off keying never below 9.6 kbaud
// R18: select pin high during power-down
// R19: start calibration, poll done bit
// R20: check lock, recalibrate when unlocked
// R21: hold data until settling timer expires
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module rmseq_top #(
  parameter int TURNON_DEF = rmseq_pkg::TURNON_CYC,
  parameter int RELOCK_DEF = rmseq_pkg::RELOCK_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic conf_sel_n,
  output logic conf_clk,
  output logic conf_dout,
  input wire logic conf_din,
  output logic data_enable,
  output logic [1:0] radio_mode
);
  import rmseq_pkg::*;

  rmseq_bus_if bus ();
  rmseq_state_t state;
  rmseq_mode_t mode;
  rmseq_mode_t target;
  logic in_init;
  logic from_pd;
  logic issued;
  logic [3:0] retries;
  logic [2:0] cmd;
  logic cmd_take;
  logic cfg_pend;
  logic [14:0] cfg_word;
  logic [TMR_W-1:0] turnon_cyc;
  logic [TMR_W-1:0] relock_cyc;
  logic [TMR_W-1:0] tmr;
  logic [31:0] ook_cfg;
  logic [31:0] rate_cfg;
  logic [15:0] bias_cfg;
  logic [7:0] last_rd;
  logic ook_bad;
  logic op_need;
  logic op_wr;
  logic [6:0] op_addr;
  logic [7:0] op_data;
  logic [31:0] next_rdata;

  // on-off keying limits: rate in 100 baud units, filter in 100 Hz units
  function automatic logic ook_invalid(input logic [15:0] rate, input logic [15:0] bw);
    logic [17:0] need;
    need = (rate <= MIN_OOK_RATE) ? {rate, 2'b00} : {1'b0, rate, 1'b0}; // R14
    return (rate < MIN_OOK_RATE) || ({2'b00, bw} < need); // R17
  endfunction : ook_invalid

  // ==========================================================
  // serial engine
  rmseq_serial u_serial (
    .core_clk(core_clk),
    .rst(rst),
    .bus(bus.engine),
    .ser_sel_n(conf_sel_n),
    .ser_clk(conf_clk),
    .ser_dout(conf_dout),
    .ser_din(conf_din)
  );

  assign ook_bad = ook_cfg[0] && ook_invalid(rate_cfg[15:0], rate_cfg[31:16]);
  assign cmd_take = (cmd != CMD_NONE) &&
                    (state == ST_ACTIVE || (state == ST_CONFIG && !cfg_pend && !issued));

  // ==========================================================
  // software registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      turnon_cyc <= TMR_W'(TURNON_DEF);
      relock_cyc <= TMR_W'(RELOCK_DEF);
      ook_cfg <= OOK_RST;
      rate_cfg <= RATE_RST;
      bias_cfg <= BIAS_RST;
    end else if (sw_wr) begin
      case (sw_addr)
        SW_TURNON: turnon_cyc <= sw_wdata[TMR_W-1:0]; // R21
        SW_RELOCK: relock_cyc <= sw_wdata[TMR_W-1:0]; // R21
        SW_OOK: ook_cfg <= sw_wdata;
        SW_RATE: rate_cfg <= sw_wdata;
        SW_BIAS: bias_cfg <= sw_wdata[15:0];
        default: ;
      endcase
    end
  end

  // command latch: a new write wins over the take in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd <= CMD_NONE;
    end else if (sw_wr && sw_addr == SW_CMD) begin
      cmd <= sw_wdata[2:0];
    end else if (cmd_take) begin
      cmd <= CMD_NONE;
    end
  end

  // raw configuration write, accepted only while configuring
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_pend <= 1'b0;
      cfg_word <= 15'h0000;
    end else if (sw_wr && sw_addr == SW_CFGW && state == ST_CONFIG && !cfg_pend) begin
      cfg_pend <= 1'b1; // R03
      cfg_word <= sw_wdata[14:0];
    end else if (state == ST_CONFIG && !issued && !bus.busy) begin
      cfg_pend <= 1'b0;
    end
  end

  // read port: data stand one cycle after the strobe only
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (sw_addr)
      SW_STATUS: next_rdata = {9'h000, cmd != CMD_NONE, ook_bad, cfg_pend, data_enable,
                               mode, retries, state};
      SW_TURNON: next_rdata[TMR_W-1:0] = turnon_cyc;
      SW_RELOCK: next_rdata[TMR_W-1:0] = relock_cyc;
      SW_OOK: next_rdata = ook_cfg;
      SW_RATE: next_rdata = rate_cfg;
      SW_BIAS: next_rdata[15:0] = bias_cfg;
      SW_LAST_RD: next_rdata[7:0] = last_rd;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sw_rdata <= 32'h0000_0000;
    end else begin
      sw_rdata <= sw_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // device access belonging to each state
  always_comb begin
    op_need = 1'b1;
    op_wr = 1'b1;
    op_addr = DEV_MAIN;
    op_data = 8'h00;
    case (state)
      ST_RST_ASSERT: op_data = main_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b0); // R02
      ST_RST_RELEASE: op_data = main_word(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      ST_CONFIG: begin
        op_need = cfg_pend;
        op_addr = cfg_word[14:8];
        op_data = cfg_word[7:0];
      end
      ST_WAKE: op_data = main_word(1'b1, 1'b1, 1'b0, 1'b0, target == MODE_TX); // R05
      ST_CAL_START: begin
        op_addr = DEV_CAL;
        op_data = CAL_START_WORD; // R19
      end
      ST_CAL_POLL, ST_LOCK_POLL: begin
        op_wr = 1'b0;
        op_addr = DEV_STATUS;
      end
      ST_BIAS: begin
        op_addr = DEV_BIAS;
        op_data = (target == MODE_TX) ? bias_cfg[15:8] : bias_cfg[7:0]; // R09
      end
      ST_OOK_GAIN: begin
        op_addr = DEV_GAIN_TWO;
        op_data = ook_cfg[15:8] | GAIN_AVG_MASK; // R13
      end
      ST_OOK_MODEM: begin
        op_addr = DEV_MODEM;
        op_data = (ook_cfg[23:16] | MODEM_MANCH) & ~MODEM_AFC; // R15 R16
      end
      ST_SETUP: op_data = main_word(1'b1, target != MODE_PD, target == MODE_RX,
                                    target == MODE_TX, target == MODE_TX);
      default: op_need = 1'b0;
    endcase
  end

  // request issue towards the serial engine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus.req <= 1'b0;
      bus.wr <= 1'b1;
      bus.addr <= 7'h00;
      bus.wdata <= 8'h00;
      issued <= 1'b0;
    end else begin
      bus.req <= 1'b0;
      if (bus.done) begin
        issued <= 1'b0;
      end else if (op_need && !issued && !bus.busy) begin
        bus.req <= 1'b1;
        bus.wr <= op_wr;
        bus.addr <= op_addr;
        bus.wdata <= op_data;
        issued <= 1'b1;
      end
    end
  end

  // last byte read from the device
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_rd <= 8'h00;
    end else if (bus.done && !bus.wr) begin
      last_rd <= bus.rdata;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_RST_ASSERT;
      mode <= MODE_PD;
      target <= MODE_PD;
      in_init <= 1'b0;
      from_pd <= 1'b0;
      retries <= 4'h0;
    end else begin
      case (state)
        ST_RST_ASSERT: if (bus.done) state <= ST_RST_RELEASE; // R02
        ST_RST_RELEASE: if (bus.done) state <= ST_CONFIG;
        ST_CONFIG: begin
          if (cmd_take && cmd == CMD_CFG_DONE) begin
            in_init <= 1'b1; // R04
            target <= MODE_RX;
            state <= ST_WAKE;
          end
        end
        ST_WAKE: if (bus.done) state <= in_init ? ST_CAL_START : ST_BIAS; // R05
        ST_CAL_START: if (bus.done) state <= ST_CAL_POLL;
        ST_CAL_POLL: begin
          if (bus.done && bus.rdata[STAT_CAL_DONE]) state <= ST_LOCK_POLL; // R19
        end
        ST_LOCK_POLL: begin
          if (bus.done) begin
            if (!bus.rdata[STAT_LOCK]) begin
              retries <= retries + 4'h1; // R20
              state <= ST_CAL_START;
            end else if (target == MODE_RX) begin
              target <= MODE_TX; // R04
              state <= ST_WAKE;
            end else begin
              target <= MODE_PD;
              in_init <= 1'b0;
              state <= ST_SETUP;
            end
          end
        end
        ST_BIAS: if (bus.done) state <= ook_cfg[0] ? ST_OOK_GAIN : ST_SETUP;
        ST_OOK_GAIN: if (bus.done) state <= ST_OOK_MODEM;
        ST_OOK_MODEM: if (bus.done) state <= ST_SETUP;
        ST_SETUP: begin
          if (bus.done) begin
            mode <= target;
            state <= (target == MODE_PD) ? ST_ACTIVE : ST_SETTLE; // R21
          end
        end
        ST_SETTLE: if (tmr == '0) state <= ST_ACTIVE;
        ST_ACTIVE: begin
          if (cmd_take && cmd == CMD_PD && mode != MODE_PD) begin
            target <= MODE_PD;
            state <= ST_SETUP;
          end else if (cmd_take && (cmd == CMD_RX || cmd == CMD_TX) && !ook_bad) begin
            if ((cmd == CMD_RX) != (mode == MODE_RX) || mode == MODE_PD) begin
              target <= (cmd == CMD_TX) ? MODE_TX : MODE_RX;
              from_pd <= (mode == MODE_PD);
              state <= (mode == MODE_PD) ? ST_WAKE : ST_BIAS; // R05 R06
            end
          end
        end
        default: state <= ST_RST_ASSERT;
      endcase
    end
  end

  // settling timer: turn-on after wake, relock after direct swap
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tmr <= '0;
    end else if (state == ST_SETUP && bus.done) begin
      tmr <= from_pd ? turnon_cyc : relock_cyc; // R07 R08 R21
    end else if (tmr != '0) begin
      tmr <= tmr - TMR_W'(1);
    end
  end

  // data hold-off and mode outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_enable <= 1'b0;
      radio_mode <= MODE_PD;
    end else begin
      data_enable <= (state == ST_ACTIVE) && (mode != MODE_PD); // R21
      radio_mode <= mode;
    end
  end
endmodule : rmseq_top
`default_nettype wire

// [verification/rmseq_chk.sv]
// concurrent checks on the sequencer top ports
`timescale 1ns/1ns
`default_nettype none
module rmseq_chk #(
  parameter int TURNON_DEF = 40,
  parameter int RELOCK_DEF = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic conf_sel_n,
  input wire logic conf_clk,
  input wire logic conf_dout,
  input wire logic conf_din,
  input wire logic data_enable,
  input wire logic [1:0] radio_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [19:0] since_chg;
  logic [1:0] prev_mode;
  logic from_pd;
  // ==========================================================
  // settle tracking
  // cycles since the mode last changed, and whether it left power-down
  always_ff @(posedge core_clk) begin
    if (rst) begin
      since_chg <= 20'h00000;
      from_pd <= 1'b1;
    end else if (radio_mode != prev_mode) begin
      since_chg <= 20'h00000;
      from_pd <= (prev_mode == 2'h0);
    end else if (since_chg != 20'hFFFFF) begin
      since_chg <= since_chg + 20'h00001;
    end
  end
  // mode seen one cycle ago
  always_ff @(posedge core_clk) begin
    prev_mode <= rst ? 2'h0 : radio_mode;
  end
  // ==========================================================
  // assertions
  a_rd_quiet: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0000_0000)
    else $error("read data outside its slot");
  a_de_mode: assert property (data_enable |-> radio_mode != 2'h0)
    else $error("data enabled in power-down");
  a_mode_legal: assert property (radio_mode != 2'h3)
    else $error("illegal mode code");
  a_chg_holds: assert property ($changed(radio_mode) |-> !data_enable)
    else $error("data enabled across a mode change");
  a_settle_time: assert property ($rose(data_enable) |->
    since_chg >= 20'(from_pd ? TURNON_DEF - 2 : RELOCK_DEF - 2))
    else $error("data enabled before settling");
  a_frame_start: assert property ($fell(conf_sel_n) |-> !conf_clk [*8])
    else $error("serial clock early in frame");
  a_data_hold: assert property ($rose(conf_clk) |-> $stable(conf_dout) [*8])
    else $error("serial data moved while clock high");
  a_sel_gap: assert property ($rose(conf_sel_n) |=> conf_sel_n)
    else $error("select gap too short");
  a_clk_in_frame: assert property (conf_clk |-> !conf_sel_n)
    else $error("serial clock outside frame");
endmodule : rmseq_chk
`default_nettype wire

// [verification/rmseq_dev_model.sv]
// behavioural device behind the serial configuration pins
`timescale 1ns/1ns
`default_nettype none
module rmseq_dev_model (
  input wire logic conf_sel_n,
  input wire logic conf_clk,
  input wire logic conf_dout,
  output logic conf_din
);
  import rmseq_pkg::*;
  logic [7:0] regs [0:127];
  logic [7:0] main_log [0:1];
  logic [15:0] sh = 16'h0000;
  logic [7:0] rd_sh = 8'h00;
  logic rd_on = 1'b0;
  logic cal_ready = 1'b0;
  int nbit = 0;
  int main_cnt = 0;
  int ncal = 0;
  logic on_off_keying;
  // zero mantissa in the deviation register keys the carrier fully on and off
  assign on_off_keying = regs[7'h30][3:0] == 4'h0;
  // registers power up cleared
  initial begin
    conf_din = 1'b0;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  // shift in address, direction and data on each rising serial edge
  always @(posedge conf_clk) begin
    sh = {sh[14:0], conf_dout};
    nbit = nbit + 1;
    if (nbit == 8) begin
      rd_on = !sh[0];
      if (sh[7:1] == DEV_STATUS) begin
        rd_sh = {cal_ready, 2'b00, cal_ready && ncal != 1, 4'h0};
        cal_ready = ncal > 0;
      end
    end
    if (nbit == 16 && sh[8]) begin
      regs[sh[15:9]] = sh[7:0];
      if (sh[15:9] == DEV_MAIN) begin
        if (main_cnt < 2) main_log[main_cnt] = sh[7:0];
        main_cnt = main_cnt + 1;
      end
      if (sh[15:9] == DEV_CAL && sh[7]) begin
        ncal = ncal + 1;
        cal_ready = 1'b0;
      end
    end
  end
  // read data at falling edges; a released line keeps toggling
  always @(negedge conf_clk or posedge conf_sel_n) begin
    if (!conf_sel_n && rd_on && nbit < 16) begin
      conf_din = rd_sh[7];
      rd_sh = {rd_sh[6:0], 1'b0};
    end else begin
      conf_din = ~conf_din;
    end
    if (conf_sel_n) begin
      nbit = 0;
      rd_on = 1'b0;
    end
  end
endmodule : rmseq_dev_model
`default_nettype wire

// [verification/rmseq_top_test.sv]
// self-checking bench for the radio mode sequencer
`timescale 1ns/1ns
`default_nettype none
module rmseq_top_test;
  import rmseq_pkg::*;
  localparam int TON = 40;
  localparam int RLK = 20;
  logic core_clk, rst, sw_wr, sw_rd, conf_sel_n, conf_clk, conf_dout, conf_din;
  logic data_enable;
  logic [7:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, d;
  logic [1:0] radio_mode;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int n0;
  logic [31:0] rates [0:3] = '{32'h0180_0060, 32'h0500_0050, 32'h017F_00C0, 32'h0180_00C0};
  rmseq_top #(.TURNON_DEF(TON), .RELOCK_DEF(RLK)) rmseq_top_inst (.core_clk(core_clk),
    .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .conf_sel_n(conf_sel_n), .conf_clk(conf_clk),
    .conf_dout(conf_dout), .conf_din(conf_din), .data_enable(data_enable),
    .radio_mode(radio_mode));
  rmseq_dev_model rmseq_dev_model_inst (.conf_sel_n(conf_sel_n), .conf_clk(conf_clk),
    .conf_dout(conf_dout), .conf_din(conf_din));
  // ==========================================================
  // clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end
  // ==========================================================
  // tasks
  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= v;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask : rd
  // poll status until a state bit shows, bounded
  task automatic wait_st(input int idx);
    logic [31:0] s;
    for (int k = 0; k < 600; k++) begin
      rd(SW_STATUS, s);
      if (s[idx] === 1'b1) break;
      repeat (16) @(posedge core_clk);
    end
    chk(32'(s[idx]), 32'h0000_0001);
  endtask : wait_st
  task automatic wait_de();
    for (int k = 0; k < 4000 && data_enable !== 1'b1; k++) @(posedge core_clk);
    chk(32'(data_enable), 32'h0000_0001);
  endtask : wait_de
  function automatic logic [31:0] dreg(input logic [6:0] a);
    return 32'(rmseq_dev_model_inst.regs[a]);
  endfunction : dreg
  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    sw_addr = 8'h00;
    sw_wdata = 32'h0000_0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(SW_TURNON, d); chk(d, 32'(TON));
    rd(SW_RELOCK, d); chk(d, 32'(RLK));
    rd(SW_OOK, d); chk(d, OOK_RST);
    rd(SW_RATE, d); chk(d, RATE_RST);
    rd(SW_BIAS, d); chk(d, 32'(BIAS_RST));
    rd(SW_CMD, d); chk(d, 32'h0000_0000);
    rd(8'h24, d); chk(d, 32'h0000_0000);
    wr(SW_TURNON, 32'h0000_0321);
    rd(SW_TURNON, d); chk(d, 32'h0000_0321);
    wr(SW_TURNON, 32'(TON));
    wait_st(2);
    chk(32'(rmseq_dev_model_inst.main_log[0][0]), 32'h0000_0000);
    chk(32'(rmseq_dev_model_inst.main_log[1][0]), 32'h0000_0001);
    wr(SW_CFGW, 32'h0000_30A0);
    repeat (440) @(posedge core_clk);
    chk(dreg(7'h30), 32'h0000_00A0);
    chk(32'(rmseq_dev_model_inst.on_off_keying), 32'h0000_0001);
    wr(SW_OOK, 32'h0000_0001);
    wr(SW_BIAS, 32'h0000_2211);
    // symbol rate and filter pairs, good and bad
    for (int i = 0; i < 4; i++) begin
      wr(SW_RATE, rates[i]);
      rd(SW_STATUS, d);
      chk(32'(d[21]), 32'(i == 1 || i == 2));
    end
    wr(SW_CMD, 32'(CMD_CFG_DONE));
    repeat (4) @(posedge core_clk);
    wait_st(12);
    rd(SW_STATUS, d);
    chk(32'(d[19:13]), 32'h0000_0001);
    chk(32'(rmseq_dev_model_inst.ncal), 32'h0000_0003);
    rd(SW_LAST_RD, d); chk(d, 32'h0000_0090);
    n0 = rmseq_dev_model_inst.main_cnt;
    wr(SW_CMD, 32'(CMD_RX));
    wait_de();
    chk(32'(radio_mode), 32'h0000_0001);
    chk(32'(rmseq_dev_model_inst.main_cnt - n0), 32'h0000_0002);
    chk(dreg(DEV_MAIN) & 32'h9F, 32'h0000_0009);
    chk(dreg(DEV_GAIN_TWO) & 32'(GAIN_AVG_MASK), 32'(GAIN_AVG_MASK));
    chk(dreg(DEV_MODEM) & 32'(MODEM_MANCH | MODEM_AFC), 32'(MODEM_MANCH));
    chk(dreg(DEV_BIAS), 32'h0000_0011);
    wr(SW_CFGW, 32'h0000_305A);
    repeat (440) @(posedge core_clk);
    chk(dreg(7'h30), 32'h0000_00A0);
    n0 = rmseq_dev_model_inst.main_cnt;
    wr(SW_CMD, 32'(CMD_TX));
    repeat (4) @(posedge core_clk);
    chk(32'(data_enable), 32'h0000_0000);
    wait_de();
    chk(32'(radio_mode), 32'h0000_0002);
    chk(32'(rmseq_dev_model_inst.main_cnt - n0), 32'h0000_0001);
    chk(dreg(DEV_MAIN) & 32'h9F, 32'h0000_0091);
    chk(dreg(DEV_BIAS), 32'h0000_0022);
    wr(SW_CMD, 32'(CMD_PD));
    repeat (4) @(posedge core_clk);
    wait_st(12);
    chk(32'({radio_mode, data_enable}), 32'h0000_0000);
    chk(dreg(DEV_MAIN) & 32'h9F, 32'h0000_001D);
    wr(SW_RATE, 32'h0500_0050);
    wr(SW_CMD, 32'(CMD_RX));
    repeat (50) @(posedge core_clk);
    chk(32'(radio_mode), 32'h0000_0000);
    rd(SW_STATUS, d);
    chk(d & 32'h0060_1FFF, 32'h0020_1000);
    end_sim();
  end
endmodule : rmseq_top_test
bind rmseq_top rmseq_chk #(.TURNON_DEF(TURNON_DEF), .RELOCK_DEF(RELOCK_DEF)) rmseq_chk_inst (
  .core_clk(core_clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
  .sw_rd(sw_rd), .sw_rdata(sw_rdata), .conf_sel_n(conf_sel_n), .conf_clk(conf_clk),
  .conf_dout(conf_dout), .conf_din(conf_din), .data_enable(data_enable),
  .radio_mode(radio_mode));
`default_nettype wire
